// ### common/fbec_regs.svh
/*
 * Event numbers, unit masks, prefix bytes and timing counts for the
 * front-end and branch event counter.
 * Assumes a single core clock and inclusion by bare name.
 */
`ifndef FBEC_REGS_SVH
`define FBEC_REGS_SVH

// event numbers
`define FBEC_EVT_XLATE      8'h82
`define FBEC_EVT_QUEUE      8'h83
`define FBEC_EVT_FSTALL     8'h86
`define FBEC_EVT_LDSLOW     8'h87
`define FBEC_EVT_BR_EXEC    8'h88
`define FBEC_EVT_BR_MISP    8'h89
`define FBEC_EVT_BR_DMISP   8'h8A
`define FBEC_EVT_CND_EXEC   8'h8B
`define FBEC_EVT_CND_MISP   8'h8C
`define FBEC_EVT_IND_EXEC   8'h8D

// unit masks
`define FBEC_UM_NONE        8'h00
`define FBEC_UM_SMALL       8'h02
`define FBEC_UM_LARGE       8'h10
`define FBEC_UM_MISSES      8'h12
`define FBEC_UM_FLUSH       8'h40
`define FBEC_UM_QFULL       8'h02

// length-changing prefix bytes
`define FBEC_PFX_OPSIZE     8'h66
`define FBEC_PFX_ADDRSIZE   8'h67

// slow length decode takes this many cycles
`define FBEC_SLOW_CYC       3'h6
`define FBEC_CNT_W          48
`define FBEC_CNT_RST        48'h0

`endif

// ### common/fbec_pkg.sv
/*
 * Types shared by the event counter and its length decode sequencer.
 * Assumes fbec_regs.svh is on the include path.
 */
`include "fbec_regs.svh"

package fbec_pkg;

    // processor operating mode seen by the length decoder
    typedef enum logic [2:0] {
        FBEC_REAL,
        FBEC_BIG_REAL,
        FBEC_PROT16,
        FBEC_PROT32,
        FBEC_LONG64
    } fbec_mode_t;

    // length decoder sequencer states
    typedef enum logic {
        FBEC_LD_IDLE,
        FBEC_LD_SLOW
    } fbec_ld_state_t;

    typedef struct packed {
        fbec_ld_state_t state;
        logic [2:0]     cnt;
        logic           slow;
        logic           done;
        logic           ready;
    } fbec_ld_st_t;

    typedef struct packed {
        logic [`FBEC_CNT_W-1:0] count;
        logic                   fetch_en;
    } fbec_top_st_t;

endpackage

// ### hdl/fbec_len_decode.sv
/*
 * Instruction length decode sequencer: picks the fast or slow path.
 * Assumes instructions are offered with valid and taken only when ready.
 */
`include "fbec_regs.svh"

module fbec_len_decode
    import fbec_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // instruction offered for length decode
    input  wire logic       insn_valid_i,
    input  wire logic [7:0] prefix_i,
    input  wire logic       has_imm_i,
    input  wire logic       has_modrm_i,
    input  wire fbec_mode_t mode_i,
    // status
    output logic            ready_o,
    output logic            done_o,
    output logic            slow_o
);

    fbec_ld_st_t st_ff;
    fbec_ld_st_t nxt_st;
    logic        accept;
    logic        pick_slow;

    // slow path selection from length-changing prefixes
    always_comb begin
        accept    = insn_valid_i && st_ff.ready;
        pick_slow = ((prefix_i == `FBEC_PFX_OPSIZE) && has_imm_i)
                 || ((prefix_i == `FBEC_PFX_ADDRSIZE) && has_modrm_i
                     && (mode_i != FBEC_LONG64));
    end

    // sequencer: fast is one cycle, slow holds for the full slow count
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        case (st_ff.state)
            FBEC_LD_IDLE: begin
                if (accept && pick_slow) begin
                    nxt_st.state = FBEC_LD_SLOW;
                    nxt_st.cnt   = `FBEC_SLOW_CYC - 3'h1;
                    nxt_st.slow  = 1'b1;
                end else if (accept) begin
                    nxt_st.done  = 1'b1;
                end
            end
            FBEC_LD_SLOW: begin
                if (st_ff.cnt == 3'h0) begin
                    nxt_st.state = FBEC_LD_IDLE;
                    nxt_st.slow  = 1'b0;
                end else begin
                    nxt_st.cnt   = st_ff.cnt - 3'h1;
                    nxt_st.done  = (st_ff.cnt == 3'h1);
                end
            end
            default: begin
                nxt_st.state = FBEC_LD_IDLE;
                nxt_st.slow  = 1'b0;
            end
        endcase
        // no new instruction while the slow path is occupied
        nxt_st.ready = (nxt_st.state == FBEC_LD_IDLE);
    end

    // state register; idle and ready out of reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '{state: FBEC_LD_IDLE, cnt: 3'h0, slow: 1'b0, done: 1'b0, ready: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign ready_o = st_ff.ready;
    assign done_o  = st_ff.done;
    assign slow_o  = st_ff.slow;

    // slow path: six busy cycles, done in the sixth
    AST_SLOW_SIX: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (accept && pick_slow) |=> (slow_o && !done_o) [*5] ##1 (slow_o && done_o) ##1 !slow_o)
        else $error("slow decode not six cycles");
    AST_FAST_ONE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (accept && !pick_slow) |=> (done_o && !slow_o && ready_o))
        else $error("fast decode not one cycle");
    AST_OPSIZE_SLOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (accept && prefix_i == `FBEC_PFX_OPSIZE && has_imm_i) |=> slow_o)
        else $error("opsize prefix with immediate not slow");
    AST_ADDR_SLOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (accept && prefix_i == `FBEC_PFX_ADDRSIZE && has_modrm_i && mode_i != FBEC_LONG64)
        |=> slow_o)
        else $error("addrsize prefix with modrm not slow");

    COV_SLOW: cover property (@(posedge clock_i) disable iff (!rst_n_i) accept && pick_slow);
    COV_FAST: cover property (@(posedge clock_i) disable iff (!rst_n_i) accept && !pick_slow);

endmodule

// ### hdl/fbec_counter.sv
/*
 * Front-end and branch event selection and counting, with the length
 * decode sequencer beneath it.
 * Assumes all event inputs come from core logic on clock_i, and that
 * event select and mask are held static by software while counting.
 * A change of selection in mid-count mixes two events in one total.
 * The 48-bit count wraps silently; software must read it often enough.
 * A clear reloads zero plus that cycle's increment, so no event is lost.
 */
`include "fbec_regs.svh"

module fbec_counter
    import fbec_pkg::*;
(
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    // software selection and control
    input  wire logic [7:0]             evt_sel_i,
    input  wire logic [7:0]             umask_i,
    input  wire logic                   count_en_i,
    input  wire logic                   count_clr_i,
    // translation buffer and fetch events
    input  wire logic                   xlate_flush_i,
    input  wire logic                   xlate_miss_small_i,
    input  wire logic                   xlate_miss_large_i,
    input  wire logic                   queue_full_i,
    input  wire logic                   fetch_cache_miss_i,
    input  wire logic                   fetch_xlate_miss_i,
    input  wire logic                   fetch_xlate_fault_i,
    input  wire logic                   fetch_stall_other_i,
    // instruction offered for length decode
    input  wire logic                   insn_valid_i,
    input  wire logic [7:0]             prefix_i,
    input  wire logic                   has_imm_i,
    input  wire logic                   has_modrm_i,
    input  wire fbec_mode_t             mode_i,
    // branch execution events
    input  wire logic                   br_exec_i,
    input  wire logic                   br_uop_i,
    input  wire logic                   br_mispred_i,
    input  wire logic                   br_dec_mispred_i,
    input  wire logic                   br_cond_i,
    input  wire logic                   br_indirect_i,
    // results
    output logic [`FBEC_CNT_W-1:0]      count_o,
    output logic                        fetch_en_o,
    output logic                        ld_ready_o,
    output logic                        ld_done_o,
    output logic                        ld_slow_o
);

    fbec_top_st_t st_ff;
    fbec_top_st_t nxt_st;
    logic [1:0]   inc;
    logic         br_real;
    logic         stall;

    // true when the selected event and mask equal a given pair
    function automatic logic sel_is(input logic [7:0] evt, input logic [7:0] um);
        sel_is = (evt_sel_i == evt) && (umask_i == um);
    endfunction

    // true for every implemented pair; written apart from the mux so the
    // idle check does not simply mirror the mux's own fall-through
    function automatic logic pair_known();
        pair_known = sel_is(`FBEC_EVT_XLATE, `FBEC_UM_FLUSH)
                  || sel_is(`FBEC_EVT_XLATE, `FBEC_UM_MISSES)
                  || sel_is(`FBEC_EVT_XLATE, `FBEC_UM_SMALL)
                  || sel_is(`FBEC_EVT_XLATE, `FBEC_UM_LARGE)
                  || sel_is(`FBEC_EVT_QUEUE, `FBEC_UM_QFULL)
                  || sel_is(`FBEC_EVT_FSTALL, `FBEC_UM_NONE)
                  || sel_is(`FBEC_EVT_LDSLOW, `FBEC_UM_NONE)
                  || sel_is(`FBEC_EVT_BR_EXEC, `FBEC_UM_NONE)
                  || sel_is(`FBEC_EVT_BR_MISP, `FBEC_UM_NONE)
                  || sel_is(`FBEC_EVT_BR_DMISP, `FBEC_UM_NONE)
                  || sel_is(`FBEC_EVT_CND_EXEC, `FBEC_UM_NONE)
                  || sel_is(`FBEC_EVT_CND_MISP, `FBEC_UM_NONE)
                  || sel_is(`FBEC_EVT_IND_EXEC, `FBEC_UM_NONE);
    endfunction

    fbec_len_decode fbec_len_decode_i (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .insn_valid_i (insn_valid_i),
        .prefix_i     (prefix_i),
        .has_imm_i    (has_imm_i),
        .has_modrm_i  (has_modrm_i),
        .mode_i       (mode_i),
        .ready_o      (ld_ready_o),
        .done_o       (ld_done_o),
        .slow_o       (ld_slow_o)
    );

    // event mux; pairs not listed add nothing
    always_comb begin
        br_real = br_exec_i && !br_uop_i;
        stall   = fetch_cache_miss_i || fetch_xlate_miss_i
               || fetch_xlate_fault_i || fetch_stall_other_i;
        inc     = 2'h0;
        if (sel_is(`FBEC_EVT_XLATE, `FBEC_UM_FLUSH))
            inc = {1'b0, xlate_flush_i};
        else if (sel_is(`FBEC_EVT_XLATE, `FBEC_UM_MISSES))
            inc = {1'b0, xlate_miss_small_i} + {1'b0, xlate_miss_large_i};
        else if (sel_is(`FBEC_EVT_XLATE, `FBEC_UM_SMALL))
            inc = {1'b0, xlate_miss_small_i};
        else if (sel_is(`FBEC_EVT_XLATE, `FBEC_UM_LARGE))
            inc = {1'b0, xlate_miss_large_i};
        else if (sel_is(`FBEC_EVT_QUEUE, `FBEC_UM_QFULL))
            inc = {1'b0, queue_full_i};
        else if (sel_is(`FBEC_EVT_FSTALL, `FBEC_UM_NONE))
            inc = {1'b0, stall};
        else if (sel_is(`FBEC_EVT_LDSLOW, `FBEC_UM_NONE))
            inc = {1'b0, ld_slow_o};
        else if (sel_is(`FBEC_EVT_BR_EXEC, `FBEC_UM_NONE))
            inc = {1'b0, br_real};
        else if (sel_is(`FBEC_EVT_BR_MISP, `FBEC_UM_NONE))
            inc = {1'b0, br_real && br_mispred_i};
        else if (sel_is(`FBEC_EVT_BR_DMISP, `FBEC_UM_NONE))
            inc = {1'b0, br_real && br_dec_mispred_i};
        else if (sel_is(`FBEC_EVT_CND_EXEC, `FBEC_UM_NONE))
            inc = {1'b0, br_real && br_cond_i};
        else if (sel_is(`FBEC_EVT_CND_MISP, `FBEC_UM_NONE))
            inc = {1'b0, br_real && br_cond_i && br_mispred_i};
        else if (sel_is(`FBEC_EVT_IND_EXEC, `FBEC_UM_NONE))
            inc = {1'b0, br_real && br_indirect_i};
        if (!count_en_i)
            inc = 2'h0;
    end

    // counter and fetch gate; an event in the clear cycle is kept
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.fetch_en = !queue_full_i;
        if (count_clr_i)
            nxt_st.count = `FBEC_CNT_RST + `FBEC_CNT_W'(inc);
        else
            nxt_st.count = st_ff.count + `FBEC_CNT_W'(inc);
    end

    // state register; fetch is allowed out of reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '{count: `FBEC_CNT_RST, fetch_en: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign count_o    = st_ff.count;
    assign fetch_en_o = st_ff.fetch_en;

    // checks on the counter and fetch gate against their causes
    AST_FLUSH_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_XLATE, `FBEC_UM_FLUSH)
         && xlate_flush_i) |=> count_o == $past(count_o) + 48'h1)
        else $error("flush not counted");
    AST_MISS_BOTH: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_XLATE, `FBEC_UM_MISSES)
         && xlate_miss_small_i && xlate_miss_large_i) |=> count_o == $past(count_o) + 48'h2)
        else $error("small and large misses not both counted");
    AST_QFULL_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_QUEUE, `FBEC_UM_QFULL)
         && queue_full_i) [*2] |=> count_o == $past(count_o, 2) + 48'h2)
        else $error("queue full cycles not counted");
    AST_FETCH_GATE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        queue_full_i |=> !fetch_en_o)
        else $error("fetch allowed while queue full");
    AST_STALL_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_FSTALL, `FBEC_UM_NONE)
         && fetch_xlate_fault_i) |=> count_o == $past(count_o) + 48'h1)
        else $error("fetch stall cycle not counted");
    AST_SLOW_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_LDSLOW, `FBEC_UM_NONE)
         && ld_slow_o) |=> count_o == $past(count_o) + 48'h1)
        else $error("slow decode cycle not counted");
    AST_UOP_EXCL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!count_clr_i && sel_is(`FBEC_EVT_BR_EXEC, `FBEC_UM_NONE) && br_uop_i)
        |=> $stable(count_o))
        else $error("micro-op branch counted");
    AST_CND_MISP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_CND_MISP, `FBEC_UM_NONE)
         && br_real && br_cond_i && br_mispred_i) |=> count_o == $past(count_o) + 48'h1)
        else $error("conditional mispredict not counted");

    // branch events, each against its own qualifier lines
    AST_BR_EXEC_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_BR_EXEC, `FBEC_UM_NONE)
         && br_exec_i && !br_uop_i) |=> count_o == $past(count_o) + 48'h1)
        else $error("executed branch not counted");
    AST_MISP_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_BR_MISP, `FBEC_UM_NONE)
         && br_exec_i && !br_uop_i && br_mispred_i) |=> count_o == $past(count_o) + 48'h1)
        else $error("mispredicted branch not counted");
    AST_DMISP_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_BR_DMISP, `FBEC_UM_NONE)
         && br_exec_i && !br_uop_i && br_dec_mispred_i) |=> count_o == $past(count_o) + 48'h1)
        else $error("decode mispredict not counted");
    AST_CND_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_CND_EXEC, `FBEC_UM_NONE)
         && br_exec_i && !br_uop_i && br_cond_i) |=> count_o == $past(count_o) + 48'h1)
        else $error("conditional branch not counted");
    AST_IND_INC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_en_i && !count_clr_i && sel_is(`FBEC_EVT_IND_EXEC, `FBEC_UM_NONE)
         && br_exec_i && !br_uop_i && br_indirect_i) |=> count_o == $past(count_o) + 48'h1)
        else $error("indirect branch not counted");

    // idle, disabled, clear and fetch release behaviour
    AST_UNIMPL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!count_clr_i && !pair_known()) |=> $stable(count_o))
        else $error("unimplemented pair changed count");
    AST_EN_LOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!count_en_i && !count_clr_i) |=> $stable(count_o))
        else $error("disabled counter changed count");
    AST_CLR_KEEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_clr_i && count_en_i && sel_is(`FBEC_EVT_BR_EXEC, `FBEC_UM_NONE)
         && br_exec_i && !br_uop_i) |=> count_o == 48'h1)
        else $error("event in clear cycle lost");
    AST_CLR_DIS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (count_clr_i && !count_en_i) |=> count_o == 48'h0)
        else $error("clear while disabled left a count");
    AST_FETCH_FREE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !queue_full_i |=> fetch_en_o)
        else $error("fetch held while queue has room");
    AST_BOUND: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !count_clr_i |=> (count_o - $past(count_o)) <= 48'h2)
        else $error("count step too large");

    COV_BR_EXEC: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        sel_is(`FBEC_EVT_BR_EXEC, `FBEC_UM_NONE) && br_real && count_en_i);
    COV_QFULL: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        queue_full_i [*3]);
    COV_CLR_EVT: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        count_clr_i && inc != 2'h0);

endmodule

// ### dv/fbec_core_model.sv
/*
 * Core pipeline model: drives fetch, decode and branch event lines.
 * Assumes the bench calls its tasks; lines change on falling edges.
 */
module fbec_core_model
    import fbec_pkg::*;
(
    // clock and decoder status
    input  wire logic       clock_i,
    input  wire logic       ld_ready_i,
    // event lines {flush,small,large}, {exec,uop,misp,dmisp,cond,ind}
    output logic [2:0]      xl_o,
    output logic            qfull_o,
    output logic [3:0]      stall_o,
    output logic [5:0]      br_o,
    // instruction offered for length decode, {imm,modrm}
    output logic            valid_o,
    output logic [7:0]      pfx_o,
    output logic [1:0]      im_o,
    output fbec_mode_t      mode_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // quiet lines at time zero
    initial begin
        {xl_o, qfull_o, stall_o, br_o, valid_o, pfx_o, im_o} = '0;
        mode_o = FBEC_REAL;
    end

    // one cycle of events; back-to-back calls give adjacent cycles
    task automatic cyc(input logic [2:0] xl, input logic q, input logic [3:0] st,
                       input logic [5:0] br);
        @(negedge clock_i);
        {xl_o, qfull_o, stall_o, br_o} = {xl, q, st, br};
    endtask

    // held until an edge sees ready, then released
    task automatic offer(input logic [7:0] p, input logic [1:0] im, input fbec_mode_t m);
        int n;
        @(negedge clock_i);
        {valid_o, pfx_o, im_o} = {1'b1, p, im};
        mode_o = m;
        n = 0;
        while (ld_ready_i !== 1'b1 && n < 20) begin
            @(negedge clock_i);
            n++;
        end
        @(negedge clock_i);
        // released fields flip so a stale value cannot pass as held
        {valid_o, pfx_o, im_o} = {1'b0, ~p, ~im};
    endtask
endmodule

// ### dv/frontend_branch_event_counter_bench.sv
/*
 * Self-checking bench for the front-end and branch event counter.
 * Assumes fbec_pkg and the core model are compiled before it.
 */
`include "fbec_regs.svh"

module frontend_branch_event_counter_bench
    import fbec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // bench-driven selection, model-driven events, design outputs
    logic                   clock_i;
    logic                   rst_n_i;
    logic [7:0]             evt_sel_i;
    logic [7:0]             umask_i;
    logic                   count_en_i;
    logic                   count_clr_i;
    logic [2:0]             xl;
    logic                   qf;
    logic [3:0]             st;
    logic [5:0]             br;
    logic                   vld;
    logic [7:0]             pfx;
    logic [1:0]             im;
    fbec_mode_t             mode;
    logic [`FBEC_CNT_W-1:0] count_o;
    logic                   fetch_en_o;
    logic                   ld_ready_o;
    logic                   ld_done_o;
    logic                   ld_slow_o;
    int                     err_total;
    int                     samples_checked;

    fbec_counter fbec_counter_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .evt_sel_i(evt_sel_i), .umask_i(umask_i),
        .count_en_i(count_en_i), .count_clr_i(count_clr_i), .xlate_flush_i(xl[2]),
        .xlate_miss_small_i(xl[1]), .xlate_miss_large_i(xl[0]), .queue_full_i(qf),
        .fetch_cache_miss_i(st[0]), .fetch_xlate_miss_i(st[1]),
        .fetch_xlate_fault_i(st[2]), .fetch_stall_other_i(st[3]), .insn_valid_i(vld),
        .prefix_i(pfx), .has_imm_i(im[1]), .has_modrm_i(im[0]), .mode_i(mode),
        .br_exec_i(br[5]), .br_uop_i(br[4]), .br_mispred_i(br[3]),
        .br_dec_mispred_i(br[2]), .br_cond_i(br[1]), .br_indirect_i(br[0]),
        .count_o(count_o), .fetch_en_o(fetch_en_o), .ld_ready_o(ld_ready_o),
        .ld_done_o(ld_done_o), .ld_slow_o(ld_slow_o)
    );

    fbec_core_model fbec_core_model_i (
        .clock_i(clock_i), .ld_ready_i(ld_ready_o), .xl_o(xl), .qfull_o(qf),
        .stall_o(st), .br_o(br), .valid_o(vld), .pfx_o(pfx), .im_o(im), .mode_o(mode)
    );

    // 125 MHz core clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    task automatic check(input string nm, input logic [`FBEC_CNT_W-1:0] seen,
                         input logic [`FBEC_CNT_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // select an event and clear while no events are pending
    task automatic sel(input logic [7:0] e, input logic [7:0] m, input logic en);
        @(negedge clock_i);
        {evt_sel_i, umask_i, count_en_i, count_clr_i} = {e, m, en, 1'b1};
        @(negedge clock_i);
        count_clr_i = 1'b0;
    endtask

    // count settles one edge after the last event
    task automatic cnt_is(input string nm, input int exp);
        fbec_core_model_i.cyc(3'h0, 1'b0, 4'h0, 6'h00);
        repeat (2) @(negedge clock_i);
        check(nm, count_o, 48'(exp));
    endtask

    task automatic t_branch;
        logic [7:0] ev [6] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D};
        int         ex [6] = '{3, 1, 1, 2, 1, 1};
        logic [5:0] pat [5] = '{6'h20, 6'h2A, 6'h27, 6'h3F, 6'h0F};
        // micro-op and non-executed branches must not count
        for (int i = 0; i < 6; i++) begin
            sel(ev[i], 8'h00, 1'b1);
            foreach (pat[j]) fbec_core_model_i.cyc(3'h0, 1'b0, 4'h0, pat[j]);
            cnt_is("branch count", ex[i]);
        end
    endtask

    task automatic t_xlate;
        logic [7:0] um [6] = '{8'h40, 8'h12, 8'h02, 8'h10, 8'h20, 8'h00};
        int         ex [6] = '{3, 2, 1, 1, 0, 0};
        logic [2:0] pat [4] = '{3'h4, 3'h4, 3'h3, 3'h4};
        for (int i = 0; i < 6; i++) begin
            sel(8'h82, um[i], 1'b1);
            foreach (pat[j]) fbec_core_model_i.cyc(pat[j], 1'b0, 4'h0, 6'h00);
            cnt_is("xlate count", ex[i]);
        end
    endtask

    task automatic t_queue;
        sel(8'h83, 8'h02, 1'b1);
        for (int i = 0; i < 5; i++) begin
            fbec_core_model_i.cyc(3'h0, 1'b1, 4'h0, 6'h00);
            if (i > 0) check("fetch_en full", fetch_en_o, 0);
        end
        cnt_is("queue count", 5);
        check("fetch_en free", fetch_en_o, 1);
        // disabled counting still gates fetch but adds nothing
        sel(8'h83, 8'h02, 1'b0);
        repeat (3) fbec_core_model_i.cyc(3'h0, 1'b1, 4'h0, 6'h00);
        cnt_is("queue disabled", 0);
    endtask

    task automatic t_stall;
        logic [3:0] pat [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h0};
        for (int i = 0; i < 2; i++) begin
            sel(8'h86, 8'(i), 1'b1);
            foreach (pat[j]) fbec_core_model_i.cyc(3'h0, 1'b0, pat[j], 6'h00);
            cnt_is("stall count", i ? 0 : 5);
        end
    endtask

    task automatic t_decode;
        logic [7:0] p [9] = '{8'h66, 8'h66, 8'h67, 8'h67, 8'h67, 8'h67, 8'h67, 8'h67, 8'h00};
        logic [1:0] f [9] = '{2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
        fbec_mode_t md [9] = '{FBEC_LONG64, FBEC_REAL, FBEC_REAL, FBEC_BIG_REAL,
            FBEC_PROT16, FBEC_PROT32, FBEC_LONG64, FBEC_PROT32, FBEC_PROT32};
        int         sl [9] = '{1, 0, 1, 1, 1, 1, 0, 0, 0};
        int         ns;
        int         nd;
        // window opens in the cycle after the taking edge
        for (int i = 0; i < 9; i++) begin
            sel(8'h87, 8'h00, 1'b1);
            fbec_core_model_i.offer(p[i], f[i], md[i]);
            ns = 0;
            nd = 0;
            repeat (10) begin
                ns += (ld_slow_o === 1'b1);
                nd += (ld_done_o === 1'b1);
                check("ready vs slow", ld_ready_o ^ ld_slow_o, 1);
                if (ld_done_o === 1'b1) check("slow at done", ld_slow_o, sl[i]);
                @(negedge clock_i);
            end
            check("slow cycles", ns, 6 * sl[i]);
            check("done pulses", nd, 1);
            check("slow count", count_o, 6 * sl[i]);
        end
    endtask

    // clear in a cycle with an event keeps that event
    task automatic t_clear;
        sel(8'h88, 8'h00, 1'b1);
        repeat (2) fbec_core_model_i.cyc(3'h0, 1'b0, 4'h0, 6'h20);
        fork
            fbec_core_model_i.cyc(3'h0, 1'b0, 4'h0, 6'h20);
            @(negedge clock_i) count_clr_i = 1'b1;
        join
        fbec_core_model_i.cyc(3'h0, 1'b0, 4'h0, 6'h00);
        count_clr_i = 1'b0;
        cnt_is("clear with event", 1);
        // reset in mid-run empties the count at once
        rst_n_i = 1'b0;
        #1;
        check("count in reset", count_o, 0);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        check("count after reset", count_o, 0);
        check("fetch_en after reset", fetch_en_o, 1);
    endtask

    initial begin
        err_total = 0;
        samples_checked = 0;
        {rst_n_i, evt_sel_i, umask_i, count_en_i, count_clr_i} = '0;
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        check("reset ready", ld_ready_o, 1);
        check("reset fetch_en", fetch_en_o, 1);
        t_branch();
        t_xlate();
        t_queue();
        t_stall();
        t_decode();
        t_clear();
        finish_test();
    end

    // run is a few hundred cycles; this limit is many times that
    initial begin
        #40000;
        err_total++;
        finish_test();
    end
endmodule
